// [hw/vil_pkg.sv]
// Constants, field layouts and carrier types for the line programmer.
// Assumes a single 50 MHz core clock and an AHB-Lite register port.
package vil_pkg;

   // Core clock and the settle time of one nonvolatile entry write
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned NVM_WRITE_MS  = 2000;
   localparam int unsigned NVM_WRITE_CYC = (CLK_HZ / 1000) * NVM_WRITE_MS;
   localparam int unsigned NVM_CNT_W     = 32;

   // Vertical interval lines 14..21 as a three-bit code, code 0 = line 14
   localparam int unsigned LINE_W      = 3;
   localparam int unsigned LINES       = 8;
   localparam int unsigned FIELDS      = 2;
   localparam int unsigned SIG_W       = 4;
   localparam logic [LINE_W-1:0] LINE_CODE_DEF_DET = 3'h5;

   // Signal codes held in the table
   localparam logic [SIG_W-1:0] SIG_PASS   = 4'h0;
   localparam logic [SIG_W-1:0] SIG_DELETE = 4'h1;
   localparam logic [SIG_W-1:0] SIG_REF    = 4'h2;

   typedef struct packed {
      logic [SIG_W-1:0] sig;
      logic             detect;
   } vil_entry_t;

   localparam vil_entry_t ENTRY_DEF_REF  = '{sig: SIG_REF, detect: 1'b1};
   localparam vil_entry_t ENTRY_DEF_IDLE = '{sig: SIG_PASS, detect: 1'b0};

   typedef enum logic [1:0] {
      MODE_PASS   = 2'b00,
      MODE_INSERT = 2'b01,
      MODE_DELETE = 2'b10,
      MODE_AUTO   = 2'b11
   } vil_ref_mode_t;

   typedef enum logic [1:0] {
      ACT_PASS   = 2'b00,
      ACT_INSERT = 2'b01,
      ACT_BLANK  = 2'b10
   } vil_act_t;

   // Remote panel pins, buttons active low (grounded = pressed)
   typedef struct packed {
      logic [LINE_W-1:0] line_code;
      logic [SIG_W-1:0]  sig_code;
      logic              detect_b;
      logic              enter_f1_b;
      logic              enter_f2_b;
      logic              mode_auto_b;
      logic              mode_delete_b;
      logic              mode_insert_b;
      logic              lock_enable_b;
      logic              lock_override_jumper;
      logic              reset_cmd_b;
   } vil_panel_t;

   localparam int unsigned PANEL_W = $bits(vil_panel_t);

   // Register map, byte addresses
   localparam int unsigned ADDR_W    = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_ENTRY  = 8'h08;

   localparam int unsigned CTRL_PANEL_EN_BIT = 0;
   localparam int unsigned CTRL_RELOAD_BIT   = 1;
   localparam logic        CTRL_PANEL_EN_RST = 1'b1;

   localparam int unsigned ST_MODE_LSB      = 0;
   localparam int unsigned ST_LOCKED_BIT    = 2;
   localparam int unsigned ST_BUSY_BIT      = 3;
   localparam int unsigned ST_AUTO_INS_BIT  = 4;
   localparam int unsigned ST_MISSING_BIT   = 5;

   localparam int unsigned ENT_IDX_LSB = 0;
   localparam int unsigned ENT_IDX_W   = 4;
   localparam int unsigned ENT_SIG_LSB = 8;
   localparam int unsigned ENT_DET_BIT = 12;

   localparam logic HRESP_OKAY = 1'b0;

endpackage

// [hw/vil_sync.sv]
// Two-stage synchroniser, one chain per bit, for the remote panel pins.
// Assumes the pins are quasi-static levels from push buttons.
`timescale 1ns/1ps
module vil_sync
   import vil_pkg::*;
#(
   parameter int unsigned        W       = 1,
   parameter logic [W-1:0]       RST_VAL = '0
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta;

   for (genvar b = 0; b < W; b++) begin : g_bit
      // Reset to the idle pin level so no false edge follows release
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            meta[b]   <= RST_VAL[b];
            sync_o[b] <= RST_VAL[b];
         end else begin
            meta[b]   <= async_i[b];
            sync_o[b] <= meta[b];
         end
      end
   end

endmodule

// [hw/vil_table.sv]
// Line programming table, indexed by field and line code.
// Assumes writes come from the controller, one line at a time.
`timescale 1ns/1ps
module vil_table
   import vil_pkg::*;
(
   input  wire logic              core_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              reload_i,
   input  wire logic [FIELDS-1:0] wr_en_i,
   input  wire logic [LINE_W-1:0] wr_line_i,
   input  wire vil_entry_t        wr_entry_i,
   input  wire logic              rd_field_i,
   input  wire logic [LINE_W-1:0] rd_line_i,
   output vil_entry_t             rd_entry_o,
   input  wire logic [ENT_IDX_W-1:0] bus_idx_i,
   output vil_entry_t             bus_entry_o
);

   vil_entry_t tbl [FIELDS][LINES];

   for (genvar f = 0; f < FIELDS; f++) begin : g_field
      for (genvar l = 0; l < LINES; l++) begin : g_line
         localparam vil_entry_t DEF = (l == LINE_CODE_DEF_DET) ?
                                      ENTRY_DEF_REF : ENTRY_DEF_IDLE;
         always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               tbl[f][l] <= DEF;
            end else if (reload_i) begin
               tbl[f][l] <= DEF;
            end else if (wr_en_i[f] && wr_line_i == LINE_W'(l)) begin
               tbl[f][l] <= wr_entry_i;
            end
         end
      end
   end

   assign rd_entry_o  = tbl[rd_field_i][rd_line_i];
   assign bus_entry_o = tbl[bus_idx_i[LINE_W]][bus_idx_i[LINE_W-1:0]];

endmodule

// [hw/vil_ctrl.sv]
// Vertical interval line programmer: remote panel, table, reference modes.
// Assumes video timing logic on core_clk_i gives line and field strobes
// and a reference-signal detector result per line.
`timescale 1ns/1ps
module vil_ctrl
   import vil_pkg::*;
#(
   parameter int unsigned NVM_CYC = NVM_WRITE_CYC
) (
   input  wire logic              core_clk_i,
   input  wire logic              rst_b_i,
   // AHB-Lite slave
   input  wire logic              hsel_i,
   input  wire logic [31:0]       haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic      [31:0]       hrdata_o,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   // Remote panel pins
   input  wire vil_panel_t        panel_i,
   // Video timing and detector, same clock domain
   input  wire logic              vi_line_start_i,
   input  wire logic              vi_field_i,
   input  wire logic [LINE_W-1:0] vi_line_i,
   input  wire logic              vi_field_end_i,
   input  wire logic              ref_result_valid_i,
   input  wire logic              ref_found_i,
   // Per-line decisions, write busy and lock state
   output vil_act_t               prog_act_o,
   output logic      [SIG_W-1:0]  prog_sig_o,
   output vil_act_t               ff_act_o,
   output logic      [SIG_W-1:0]  ff_sig_o,
   output logic                   nvm_busy_o,
   output logic                   locked_o
);

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_NVM    = 2'b01,
      ST_RELOAD = 2'b10
   } vil_state_t;

   localparam vil_panel_t PANEL_IDLE = '{
      line_code: '1, sig_code: '1, detect_b: 1'b1, enter_f1_b: 1'b1,
      enter_f2_b: 1'b1, mode_auto_b: 1'b1, mode_delete_b: 1'b1,
      mode_insert_b: 1'b1, lock_enable_b: 1'b1,
      lock_override_jumper: 1'b0, reset_cmd_b: 1'b1};

   vil_panel_t        pnl;
   vil_panel_t        pnl_prev;
   vil_state_t        state;
   vil_state_t        next_state;
   logic [NVM_CNT_W-1:0] nvm_cnt;
   logic              enter_f1;
   logic              enter_f2;
   logic              reset_cmd;
   logic              accept;
   logic              do_write;
   logic              do_reload;
   logic              sw_reload;
   logic              panel_en;
   vil_ref_mode_t     mode;
   vil_entry_t        wr_entry;
   vil_entry_t        rd_entry;
   vil_entry_t        bus_entry;
   logic [ENT_IDX_W-1:0] entry_idx;
   logic              missing_acc;
   logic              auto_insert;
   logic              ap_valid;
   logic              dp_write;
   logic [ADDR_W-1:0] dp_addr;
   logic [31:0]       rd_mux;
   vil_act_t          next_prog_act;
   logic [SIG_W-1:0]  next_prog_sig;
   vil_act_t          next_ff_act;
   logic [SIG_W-1:0]  next_ff_sig;

   vil_sync #(
      .W       (PANEL_W),
      .RST_VAL (PANEL_IDLE)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .async_i    (panel_i),
      .sync_o     (pnl)
   );

   // Button edges, taken only from the synchronised copy
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pnl_prev <= PANEL_IDLE;
      end else begin
         pnl_prev <= pnl;
      end
   end

   assign enter_f1  = pnl_prev.enter_f1_b & ~pnl.enter_f1_b;
   assign enter_f2  = pnl_prev.enter_f2_b & ~pnl.enter_f2_b;
   assign reset_cmd = pnl_prev.reset_cmd_b & ~pnl.reset_cmd_b;

   assign locked_o = pnl.lock_override_jumper | pnl.lock_enable_b;
   assign accept   = ~locked_o;

   always_comb begin
      if (!pnl.mode_auto_b) begin
         mode = MODE_AUTO;
      end else if (!pnl.mode_delete_b) begin
         mode = MODE_DELETE;
      end else if (!pnl.mode_insert_b) begin
         mode = MODE_INSERT;
      end else begin
         mode = MODE_PASS;
      end
   end

   assign do_reload = (reset_cmd | sw_reload) & accept;

   assign do_write = (state == ST_IDLE) & accept & panel_en & ~do_reload &
                     (enter_f1 | enter_f2);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (do_reload) begin
               next_state = ST_RELOAD;
            end else if (do_write) begin
               next_state = ST_NVM;
            end
         end
         ST_NVM: begin
            if (do_reload) begin
               next_state = ST_RELOAD;
            end else if (nvm_cnt == '0) begin
               next_state = ST_IDLE;
            end
         end
         ST_RELOAD: next_state = ST_IDLE;
         default:   next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nvm_cnt <= '0;
      end else if (do_write) begin
         nvm_cnt <= NVM_CYC[NVM_CNT_W-1:0] - 1'b1;
      end else if (state == ST_NVM && nvm_cnt != '0) begin
         nvm_cnt <= nvm_cnt - 1'b1;
      end
   end

   assign nvm_busy_o = (state == ST_NVM);

   always_comb begin
      wr_entry.sig    = pnl.sig_code;
      wr_entry.detect = 1'b0;
      if (pnl.sig_code == SIG_REF) begin
         wr_entry.detect = ~pnl.detect_b | rd_entry.detect;
      end
   end

   vil_table u_table (
      .core_clk_i  (core_clk_i),
      .rst_b_i     (rst_b_i),
      .reload_i    (state == ST_RELOAD),
      .wr_en_i     ({enter_f2, enter_f1} & {FIELDS{do_write}}),
      .wr_line_i   (pnl.line_code),
      .wr_entry_i  (wr_entry),
      .rd_field_i  (do_write ? enter_f2 & ~enter_f1 : vi_field_i),
      .rd_line_i   (do_write ? pnl.line_code : vi_line_i),
      .rd_entry_o  (rd_entry),
      .bus_idx_i   (entry_idx),
      .bus_entry_o (bus_entry)
   );

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         missing_acc <= 1'b0;
         auto_insert <= 1'b0;
      end else if (vi_field_end_i && vi_field_i) begin
         auto_insert <= missing_acc |
                        (ref_result_valid_i & ~ref_found_i & rd_entry.detect);
         missing_acc <= 1'b0;
      end else if (ref_result_valid_i && rd_entry.detect && !ref_found_i
                   && !do_write) begin
         missing_acc <= 1'b1;
      end
   end

   // Per-line action from the table entry and reference mode
   always_comb begin
      next_prog_act = ACT_PASS;
      next_prog_sig = rd_entry.sig;
      next_ff_act   = ACT_BLANK;
      next_ff_sig   = rd_entry.sig;
      if (rd_entry.sig == SIG_DELETE) begin
         next_prog_act = ACT_BLANK;
      end else if (rd_entry.sig == SIG_REF) begin
         unique case (mode)
            MODE_PASS:   next_prog_act = ACT_PASS;
            MODE_INSERT: next_prog_act = ACT_INSERT;
            MODE_DELETE: next_prog_act = ACT_BLANK;
            MODE_AUTO:   next_prog_act = auto_insert ? ACT_INSERT
                                                     : ACT_PASS;
         endcase
      end else if (rd_entry.sig != SIG_PASS) begin
         next_prog_act = ACT_INSERT;
      end
      if (next_prog_act == ACT_INSERT) begin
         next_ff_act = ACT_INSERT;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prog_act_o <= ACT_PASS;
         prog_sig_o <= SIG_PASS;
         ff_act_o   <= ACT_BLANK;
         ff_sig_o   <= SIG_PASS;
      end else if (vi_line_start_i && !do_write) begin
         prog_act_o <= next_prog_act;
         prog_sig_o <= next_prog_sig;
         ff_act_o   <= next_ff_act;
         ff_sig_o   <= next_ff_sig;
      end else if (vi_field_end_i) begin
         prog_act_o <= ACT_PASS;
         ff_act_o   <= ACT_BLANK;
      end
   end

   // AHB-Lite slave, zero wait states
   assign hreadyout_o = 1'b1;
   assign hresp_o     = HRESP_OKAY;
   assign ap_valid    = hsel_i & htrans_i[1] & hready_i;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dp_write <= 1'b0;
         dp_addr  <= '0;
      end else begin
         dp_write <= ap_valid & hwrite_i;
         dp_addr  <= haddr_i[ADDR_W-1:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         panel_en  <= CTRL_PANEL_EN_RST;
         sw_reload <= 1'b0;
         entry_idx <= '0;
      end else begin
         sw_reload <= 1'b0;
         if (dp_write && dp_addr == REG_CTRL) begin
            panel_en  <= hwdata_i[CTRL_PANEL_EN_BIT];
            sw_reload <= hwdata_i[CTRL_RELOAD_BIT];
         end
         if (dp_write && dp_addr == REG_ENTRY) begin
            entry_idx <= hwdata_i[ENT_IDX_LSB +: ENT_IDX_W];
         end
      end
   end

   always_comb begin
      rd_mux = '0;
      unique case (haddr_i[ADDR_W-1:0])
         REG_CTRL: rd_mux[CTRL_PANEL_EN_BIT] = panel_en;
         REG_STATUS: begin
            rd_mux[ST_MODE_LSB +: 2]  = mode;
            rd_mux[ST_LOCKED_BIT]     = locked_o;
            rd_mux[ST_BUSY_BIT]       = nvm_busy_o;
            rd_mux[ST_AUTO_INS_BIT]   = auto_insert;
            rd_mux[ST_MISSING_BIT]    = missing_acc;
         end
         REG_ENTRY: begin
            rd_mux[ENT_IDX_LSB +: ENT_IDX_W] = entry_idx;
            rd_mux[ENT_SIG_LSB +: SIG_W]     = bus_entry.sig;
            rd_mux[ENT_DET_BIT]              = bus_entry.detect;
         end
         default: rd_mux = '0;
      endcase
   end

   // Read data latched at the address phase, stands in the data phase
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hrdata_o <= '0;
      end else if (ap_valid && !hwrite_i) begin
         hrdata_o <= rd_mux;
      end
   end

endmodule

// [test/vil_chk.sv]
// Port checker for the line programmer, bound into every vil_ctrl.
// Assumes panel pins pass two sync stages before the core sees them.
`timescale 1ns/1ps
module vil_chk
   import vil_pkg::*;
#(
   parameter int unsigned NVM_CYC = NVM_WRITE_CYC
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire vil_panel_t       panel_i,
   input  wire logic             vi_line_start_i,
   input  wire logic             vi_field_end_i,
   input  wire vil_act_t         prog_act_o,
   input  wire logic [SIG_W-1:0] prog_sig_o,
   input  wire vil_act_t         ff_act_o,
   input  wire logic [SIG_W-1:0] ff_sig_o,
   input  wire logic             nvm_busy_o,
   input  wire logic             locked_o
);
   logic [NVM_CNT_W-1:0] busy_cnt;

   // Busy length counted here, too long for a repetition
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_cnt <= '0;
      end else if (nvm_busy_o) begin
         busy_cnt <= busy_cnt + 1'b1;
      end else begin
         busy_cnt <= '0;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_busy_len;
      $fell(nvm_busy_o) |-> busy_cnt == NVM_CYC;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("write busy length wrong");
   property p_lock_blocks;
      locked_o [*2] |=> !$rose(nvm_busy_o);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks)
      else $error("entry written while locked");
   property p_unlock;
      (!panel_i.lock_enable_b && !panel_i.lock_override_jumper) [*5]
         |-> !locked_o;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("locked while switch enables");
   property p_override;
      panel_i.lock_override_jumper [*5] |-> locked_o;
   endproperty
   a_override: assert property (p_override)
      else $error("jumper does not force lock");
   property p_field_end;
      vi_field_end_i |=> prog_act_o == ACT_PASS && ff_act_o == ACT_BLANK;
   endproperty
   a_field_end: assert property (p_field_end)
      else $error("outputs not idle after field end");
   property p_hold;
      !$past(vi_line_start_i) && !$past(vi_field_end_i)
         |-> $stable(prog_act_o) && $stable(prog_sig_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("line decision changed between strobes");
   property p_ins_code;
      prog_act_o == ACT_INSERT
         |-> prog_sig_o != SIG_PASS && prog_sig_o != SIG_DELETE;
   endproperty
   a_ins_code: assert property (p_ins_code)
      else $error("insert with non-signal code");
   property p_ff_copy;
      prog_act_o == ACT_INSERT && prog_sig_o != SIG_REF
         |-> ff_act_o == ACT_INSERT && ff_sig_o == prog_sig_o;
   endproperty
   a_ff_copy: assert property (p_ff_copy)
      else $error("full field misses inserted signal");
endmodule

bind vil_ctrl vil_chk #(.NVM_CYC(NVM_CYC)) u_chk (
   .core_clk_i      (core_clk_i),
   .rst_b_i         (rst_b_i),
   .panel_i         (panel_i),
   .vi_line_start_i (vi_line_start_i),
   .vi_field_end_i  (vi_field_end_i),
   .prog_act_o      (prog_act_o),
   .prog_sig_o      (prog_sig_o),
   .ff_act_o        (ff_act_o),
   .ff_sig_o        (ff_sig_o),
   .nvm_busy_o      (nvm_busy_o),
   .locked_o        (locked_o)
);

// [test/vil_panel_model.sv]
// Remote panel model: pulled-up push buttons, lock switch and jumper.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/1ps
module vil_panel_model
   import vil_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic nvm_busy_i,
   output vil_panel_t panel_o
);
   initial begin
      panel_o = '1;
      panel_o.lock_enable_b = '0;
      panel_o.lock_override_jumper = '0;
   end

   task automatic enter_entry(input logic [LINE_W-1:0] line,
                              input logic [SIG_W-1:0] sig,
                              input logic det,
                              input logic [1:0] fld);
      @(posedge core_clk_i);
      panel_o.line_code <= line;
      panel_o.sig_code <= sig;
      panel_o.detect_b <= ~det;
      repeat (2) @(posedge core_clk_i);
      panel_o.enter_f1_b <= ~fld[0];
      panel_o.enter_f2_b <= ~fld[1];
      repeat (6) @(posedge core_clk_i);
      panel_o.enter_f1_b <= '1;
      panel_o.enter_f2_b <= '1;
      panel_o.detect_b <= '1;
      // no button until the write settles
      repeat (3) @(posedge core_clk_i);
      while (nvm_busy_i) @(posedge core_clk_i);
   endtask

   task automatic pins(input logic [2:0] mode_b, input logic lock_b,
                       input logic jmp, input logic rst_b);
      @(posedge core_clk_i);
      {panel_o.mode_auto_b, panel_o.mode_delete_b,
       panel_o.mode_insert_b} <= mode_b;
      panel_o.lock_enable_b <= lock_b;
      panel_o.lock_override_jumper <= jmp;
      panel_o.reset_cmd_b <= rst_b;
      repeat (5) @(posedge core_clk_i);
   endtask
endmodule

// [test/vil_tb.sv]
// Self-checking bench: panel model, register reads, video strobes.
// Assumes a shortened entry write time for simulation.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      bad_count++; \
      $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
   end \
end
module testbench;
   import vil_pkg::*;
   localparam int unsigned NVM_TB = 20;
   localparam int unsigned LIMIT  = 8000;
   logic              clk = '0;
   logic              rst_b = '0;
   logic              hsel = '0;
   logic [31:0]       haddr = '0;
   logic [1:0]        htrans = '0;
   logic              hwrite = '0;
   logic [31:0]       hwdata = '0;
   logic [31:0]       hrdata;
   logic              hready;
   logic              hresp;
   vil_panel_t        panel;
   logic              line_start = '0;
   logic              vi_field = '0;
   logic [LINE_W-1:0] vi_line = '0;
   logic              field_end = '0;
   logic              ref_valid = '0;
   logic              ref_found = '0;
   vil_act_t          prog_act;
   vil_act_t          ff_act;
   logic [SIG_W-1:0]  prog_sig;
   logic [SIG_W-1:0]  ff_sig;
   logic              busy;
   logic              locked;
   logic [31:0]       rd;
   int                bad_count = 0;
   int                total_checks = 0;
   int                cyc = 0;

   always #10 clk = ~clk;

   vil_ctrl #(.NVM_CYC(NVM_TB)) dut (
      .core_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .panel_i(panel),
      .vi_line_start_i(line_start), .vi_field_i(vi_field),
      .vi_line_i(vi_line), .vi_field_end_i(field_end),
      .ref_result_valid_i(ref_valid), .ref_found_i(ref_found),
      .prog_act_o(prog_act), .prog_sig_o(prog_sig), .ff_act_o(ff_act),
      .ff_sig_o(ff_sig), .nvm_busy_o(busy), .locked_o(locked));

   vil_panel_model u_panel (
      .core_clk_i(clk), .nvm_busy_i(busy), .panel_o(panel));

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge clk);
      hsel <= '1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      hsel <= '0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      rd = hrdata;
      `CHK("hresp", HRESP_OKAY, hresp)
   endtask

   task automatic ent(input logic [3:0] idx, input logic [3:0] sig,
                      input logic det);
      ahb('1, REG_ENTRY, {28'h0, idx});
      ahb('0, REG_ENTRY, 32'h0);
      `CHK("entry sig", sig, rd[ENT_SIG_LSB +: SIG_W])
      `CHK("entry det", det, rd[ENT_DET_BIT])
   endtask

   task automatic vl(input logic f, input logic [LINE_W-1:0] l,
                     input logic fnd, input logic chk,
                     input vil_act_t pa, input logic [SIG_W-1:0] ps);
      @(posedge clk);
      vi_field <= f;
      vi_line <= l;
      line_start <= '1;
      @(posedge clk);
      line_start <= '0;
      ref_valid <= '1;
      ref_found <= fnd;
      @(posedge clk);
      ref_valid <= '0;
      if (chk) begin
         `CHK("prog act", pa, prog_act)
         if (pa == ACT_INSERT)
            `CHK("prog sig", ps, prog_sig)
      end
   endtask

   task automatic fend(input logic f);
      @(posedge clk);
      vi_field <= f;
      field_end <= '1;
      @(posedge clk);
      field_end <= '0;
   endtask

   task automatic scen_reset();
      ent(4'h5, SIG_REF, '1);
      ent(4'hD, SIG_REF, '1);
      ent(4'h0, SIG_PASS, '0);
      ahb('0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      ahb('0, REG_STATUS, 32'h0);
      `CHK("mode", 2'h0, rd[1:0])
   endtask

   task automatic scen_program();
      u_panel.enter_entry(3'h0, 4'h5, '0, 2'h3);
      ent(4'h0, 4'h5, '0);
      ent(4'h8, 4'h5, '0);
      vl('0, 3'h0, '0, '1, ACT_INSERT, 4'h5);
      `CHK("ff act", ACT_INSERT, ff_act)
      `CHK("ff sig", 4'h5, ff_sig)
      fend('0);
      @(posedge clk);
      `CHK("idle act", ACT_PASS, prog_act)
   endtask

   task automatic scen_detect();
      u_panel.enter_entry(3'h6, SIG_REF, '1, 2'h3);
      ent(4'h6, SIG_REF, '1);
      ent(4'hE, SIG_REF, '1);
      ent(4'h5, SIG_REF, '1);
      u_panel.enter_entry(3'h5, 4'h5, '0, 2'h1);
      ent(4'h5, 4'h5, '0);
      ent(4'hD, SIG_REF, '1);
   endtask

   task automatic scen_modes();
      logic [2:0] mb [3] = '{3'h7, 3'h6, 3'h5};
      vil_act_t   ea [3] = '{ACT_PASS, ACT_INSERT, ACT_BLANK};
      for (int i = 0; i < 3; i++) begin
         u_panel.pins(mb[i], '0, '0, '1);
         vl('0, 3'h6, '1, '1, ea[i], SIG_REF);
         fend('0);
         ahb('0, REG_STATUS, 32'h0);
         `CHK("mode", i[1:0], rd[1:0])
      end
   endtask

   task automatic scen_auto();
      u_panel.pins(3'h3, '0, '0, '1);
      vl('0, 3'h6, '1, '0, ACT_PASS, 4'h0);
      fend('0);
      vl('1, 3'h5, '1, '0, ACT_PASS, 4'h0);
      vl('1, 3'h6, '1, '0, ACT_PASS, 4'h0);
      fend('1);
      vl('0, 3'h6, '1, '1, ACT_PASS, 4'h0);
      fend('0);
      vl('1, 3'h5, '0, '0, ACT_PASS, 4'h0);
      vl('1, 3'h6, '1, '0, ACT_PASS, 4'h0);
      fend('1);
      vl('0, 3'h6, '1, '1, ACT_INSERT, SIG_REF);
      fend('0);
      ahb('0, REG_STATUS, 32'h0);
      `CHK("auto ins", 1'h1, rd[ST_AUTO_INS_BIT])
      // A clean frame must withdraw the insertion again
      vl('1, 3'h5, '1, '0, ACT_PASS, 4'h0);
      vl('1, 3'h6, '1, '0, ACT_PASS, 4'h0);
      fend('1);
      vl('0, 3'h6, '1, '1, ACT_PASS, 4'h0);
      fend('0);
   endtask

   task automatic scen_lock();
      u_panel.pins(3'h7, '1, '0, '1);
      `CHK("locked", 1'h1, locked)
      u_panel.enter_entry(3'h1, 4'h7, '0, 2'h3);
      ent(4'h1, SIG_PASS, '0);
      u_panel.pins(3'h7, '1, '0, '0);
      u_panel.pins(3'h7, '1, '0, '1);
      ent(4'h0, 4'h5, '0);
      u_panel.pins(3'h7, '0, '1, '1);
      `CHK("locked", 1'h1, locked)
      u_panel.enter_entry(3'h1, 4'h7, '0, 2'h1);
      ent(4'h1, SIG_PASS, '0);
      u_panel.pins(3'h7, '0, '0, '0);
      u_panel.pins(3'h7, '0, '0, '1);
      `CHK("locked", 1'h0, locked)
      ent(4'h0, SIG_PASS, '0);
      ent(4'h5, SIG_REF, '1);
      u_panel.enter_entry(3'h3, 4'h6, '0, 2'h1);
      ent(4'h3, 4'h6, '0);
      ahb('1, REG_CTRL, 32'h3);
      ent(4'h3, SIG_PASS, '0);
      // Panel gate off: enters must be dropped
      ahb('1, REG_CTRL, 32'h0);
      u_panel.enter_entry(3'h2, 4'h6, '0, 2'h1);
      ent(4'h2, SIG_PASS, '0);
      ahb('0, REG_CTRL, 32'h0);
      `CHK("panel en", 32'h0, rd)
      ahb('1, REG_CTRL, 32'h1);
   endtask

   task automatic results();
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         results();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= '1;
      scen_reset();
      scen_program();
      scen_detect();
      scen_modes();
      scen_auto();
      scen_lock();
      results();
   end
endmodule
